// *** inc/nfh_regs.svh ***
// Functional notes
// - Hold chip select low for every access
// - Address latch high marks address cycles
// - Command latch high marks command cycles
// - Open-drain ready/busy needs a pull-up
// - Five address cycles: column two, row three
// - Unused upper address bits driven low
// - Data input: both latches low, read high
`ifndef NFH_REGS_SVH
`define NFH_REGS_SVH
// Array geometry
`define NFH_PAGE_MAIN 2048
`define NFH_PAGE_SPARE 64
`define NFH_BLOCKS 2048
`define NFH_PAGES_PER_BLOCK 64
`define NFH_COL_BITS 12
`define NFH_ROW_BITS 17
`define NFH_PLANE_BIT 6
`define NFH_ADDR_CYCLES 5
// Strobe timing in ns and in 4 ns cycles (least times round up)
`define NFH_CLK_PERIOD_NS 4
`define NFH_STROBE_LOW_NS 12
`define NFH_STROBE_HIGH_NS 10
`define NFH_READ_ACCESS_DELAY_NS 20
`define NFH_STROBE_LOW_CYC \
  ((`NFH_STROBE_LOW_NS + `NFH_CLK_PERIOD_NS - 1) / `NFH_CLK_PERIOD_NS)
`define NFH_STROBE_HIGH_CYC \
  ((`NFH_STROBE_HIGH_NS + `NFH_CLK_PERIOD_NS - 1) / `NFH_CLK_PERIOD_NS)
`define NFH_READ_ACCESS_CYC \
  ((`NFH_READ_ACCESS_DELAY_NS + `NFH_CLK_PERIOD_NS - 1) / `NFH_CLK_PERIOD_NS)
`define NFH_CNT_W 4
`endif

// *** inc/nfh_pkg.sv ***
package nfh_pkg;
  // Kind of bus cycle requested by the user side
  typedef enum logic [2:0] {
    NFH_OP_CMD = 3'h0,
    NFH_OP_ADDR = 3'h1,
    NFH_OP_WRITE = 3'h2,
    NFH_OP_READ = 3'h3,
    NFH_OP_ADDR5 = 3'h4
  } nfh_op_type;
  // One user request
  typedef struct packed {
    nfh_op_type op;
    logic [7:0] data;
    logic [11:0] column;
    logic [16:0] row;
  } nfh_req_type;
  // Pins driven toward the flash
  typedef struct packed {
    logic chip_sel_n;
    logic cmd_latch;
    logic addr_latch;
    logic write_strobe_n;
    logic read_strobe_n;
    logic write_prot_n;
    logic [7:0] io_out;
    logic [7:0] io_oe;
  } nfh_pins_type;
endpackage

// *** verilog/nfh_sync.sv ***
`timescale 1ns/10ps
// Two-flop synchroniser for pin inputs, two stages per bit
module nfh_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  // First stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule

// *** verilog/nfh_host.sv ***
`timescale 1ns/10ps
`include "nfh_regs.svh"
// Host-side sequencer that drives a NAND flash through its pins
// Requests are taken one at a time; each becomes one or more bus cycles
module nfh_host
  import nfh_pkg::*;
#(
  // Phase lengths in clock cycles
  parameter int STROBE_LOW = `NFH_STROBE_LOW_CYC,
  parameter int STROBE_HIGH = `NFH_STROBE_HIGH_CYC,
  parameter int READ_ACCESS = `NFH_READ_ACCESS_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  output logic req_ready,
  input wire nfh_req_type req,
  input wire logic chip_en,
  input wire logic write_prot_n,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic busy,
  output nfh_pins_type pins,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  // Sequencer states, one-hot
  // One-hot codes keep the pin decode to single-bit compares
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WLOW = 5'b00010,
    ST_WHIGH = 5'b00100,
    ST_RLOW = 5'b01000,
    ST_RHIGH = 5'b10000
  } nfh_state_type;

  // Sequencer state and its counters
  nfh_state_type state_q, state_d; // Current phase of the bus cycle
  logic [`NFH_CNT_W-1:0] cnt_q, cnt_d; // Phase timer
  logic [2:0] acyc_q, acyc_d; // Address cycle index
  logic [2:0] acyc_last_q, acyc_last_d; // Last address cycle index
  nfh_req_type cur_q, cur_d; // Request in flight
  // Read return path
  logic [7:0] rd_data_q, rd_data_d; // Last byte taken off the bus
  logic rd_valid_q, rd_valid_d; // One-cycle strobe beside rd_data
  // Pin inputs after the synchroniser
  logic [7:0] io_sync; // Bus level, two flops late
  logic rb_sync; // Ready line, two flops late; low means busy
  logic last_phase; // Phase timer has run out
  // Pin values are built whole here and leave through one assignment
  nfh_pins_type pins_d;

  // Pin inputs pass two flops; the bus is only read long after it has
  // settled, so bits landing a cycle apart do no harm
  nfh_sync #(.WIDTH(9)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({ready_busy_n, io_in}),
    .sync_out({rb_sync, io_sync})
  );

  // Byte for a given address cycle, unused upper bits forced low
  function automatic logic [7:0] addr_byte(input logic [2:0] idx, input nfh_req_type r);
    logic [7:0] b;
    // Index 4 and above send the row top bit
    b = 8'h00;
    if (idx == 3'd0) begin
      // Column low byte goes first
      b = r.column[7:0];
    end else if (idx == 3'd1) begin
      // Column top nibble; upper half of the byte stays low
      b = {4'h0, r.column[11:8]};
    end else if (idx == 3'd2) begin
      // Row low byte; its bit 6 is the plane select
      b = r.row[7:0];
    end else if (idx == 3'd3) begin
      // Row middle byte
      b = r.row[15:8];
    end else begin
      // Row top bit alone; the other seven are held low
      b = {7'h00, r.row[16]};
    end
    return b;
  endfunction

  // The timer counts down; zero marks the final cycle of a phase
  assign last_phase = (cnt_q == '0);

  // Next-state logic of the sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    acyc_d = acyc_q;
    acyc_last_d = acyc_last_q;
    cur_d = cur_q;
    rd_data_d = rd_data_q;
    rd_valid_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // Only start when the flash is ready and selected
        if (req_valid && chip_en && rb_sync) begin
          // Capture the whole request; the user side may change it next cycle
          cur_d = req;
          acyc_d = 3'd0;
          // Plain address sends the column only, the long form adds the row
          acyc_last_d = (req.op == NFH_OP_ADDR5) ? 3'd4 : 3'd1;
          cnt_d = `NFH_CNT_W'(STROBE_LOW - 1);
          state_d = (req.op == NFH_OP_READ) ? ST_RLOW : ST_WLOW;
        end
      end
      ST_WLOW: begin
        // Write strobe low with the byte on the bus
        if (last_phase) begin
          // Strobe rises next cycle; the flash latches on that edge
          cnt_d = `NFH_CNT_W'(STROBE_HIGH - 1);
          state_d = ST_WHIGH;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_WHIGH: begin
        // Strobe high; latches and data still held for the hold time
        if (!last_phase) begin
          cnt_d = cnt_q - 1'b1;
        end else if ((cur_q.op == NFH_OP_ADDR || cur_q.op == NFH_OP_ADDR5)
                     && acyc_q != acyc_last_q) begin
          // Further address bytes follow back to back
          acyc_d = acyc_q + 3'd1;
          cnt_d = `NFH_CNT_W'(STROBE_LOW - 1);
          state_d = ST_WLOW;
        end else begin
          // Cycle complete; idle for at least one cycle
          state_d = ST_IDLE;
        end
      end
      ST_RLOW: begin
        // Hold read strobe low past the access delay, then sample
        // The byte seen here left the pins two flops ago and has settled
        if (last_phase) begin
          rd_data_d = io_sync;
          rd_valid_d = 1'b1;
          cnt_d = `NFH_CNT_W'(STROBE_HIGH - 1);
          state_d = ST_RHIGH;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_RHIGH: begin
        // Strobe high time before the next cycle may begin
        if (last_phase) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        // An illegal code recovers to idle
        state_d = ST_IDLE;
      end
    endcase
    // Low phase lasts the access delay, one cycle of margin before the
    // first flop, and both flops; one cycle less would sample the bus
    // at the very edge where the flash changes it
    if (state_q == ST_IDLE && state_d == ST_RLOW) begin
      cnt_d = `NFH_CNT_W'(READ_ACCESS + 2);
    end
  end

  // Sequencer registers; they only register the next values above
  // Reset leaves every strobe high and the bus released
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      acyc_q <= 3'd0;
      acyc_last_q <= 3'd0;
      cur_q <= '0;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      // Normal running
      state_q <= state_d;
      cnt_q <= cnt_d;
      acyc_q <= acyc_d;
      acyc_last_q <= acyc_last_d;
      cur_q <= cur_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // Pin drive, decoded from state; latches never both high
  // Built in a variable first: setting the port field by field would
  // show passing edges on the strobes, and the flash acts on every edge
  always_comb begin
    // Idle values: strobes high, latches low, bus released
    pins_d = '0;
    pins_d.chip_sel_n = !(chip_en || state_q != ST_IDLE);
    pins_d.write_prot_n = write_prot_n;
    pins_d.write_strobe_n = (state_q != ST_WLOW);
    pins_d.read_strobe_n = (state_q != ST_RLOW);
    if (state_q == ST_WLOW || state_q == ST_WHIGH) begin
      // Latch selects and data stay put across the whole strobe
      pins_d.cmd_latch = (cur_q.op == NFH_OP_CMD);
      pins_d.addr_latch = (cur_q.op == NFH_OP_ADDR || cur_q.op == NFH_OP_ADDR5);
      pins_d.io_oe = 8'hFF;
      if (pins_d.addr_latch) begin
        // Address bytes come from the request in cycle order
        pins_d.io_out = addr_byte(acyc_q, cur_q);
      end else begin
        // Command or data byte
        pins_d.io_out = cur_q.data;
      end
    end
  end
  // One whole assignment per change, so every pin moves at once
  assign pins = pins_d;

  // Ready for a request only when idle, selected and the flash is ready
  assign req_ready = (state_q == ST_IDLE) && chip_en && rb_sync;
  // Read byte and its strobe straight from flops
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  // The line idles high through its pull-up; low means the flash is working
  assign busy = !rb_sync;
endmodule

// *** dv/nfh_monitor.sv ***
`timescale 1ns/10ps
// Pin protocol checks on the host, clocked by the host clock
module nfh_monitor
  import nfh_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic chip_en,
  input wire logic write_prot_n,
  input wire logic rd_valid,
  input wire logic busy,
  input wire nfh_pins_type pins,
  input wire logic ready_busy_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_cs_enabled: assert property (chip_en |-> !pins.chip_sel_n)
    else $error("chip select high while enabled");
  a_cs_float: assert property (pins.chip_sel_n |-> pins.io_oe == 8'h00)
    else $error("bus driven while deselected");
  a_one_latch: assert property (!(pins.cmd_latch && pins.addr_latch))
    else $error("both latches high");
  a_wp_pass: assert property (pins.write_prot_n == write_prot_n)
    else $error("write protect not passed on");
  // Write strobe low for three cycles with the bus driven
  a_write_len: assert property ($fell(pins.write_strobe_n) |->
    (!pins.write_strobe_n && pins.io_oe == 8'hFF)[*3] ##1 pins.write_strobe_n)
    else $error("write strobe pulse wrong");
  // Read strobe low eight cycles, bus released, write strobe idle
  a_read_len: assert property ($fell(pins.read_strobe_n) |->
    (!pins.read_strobe_n && pins.io_oe == 8'h00 && pins.write_strobe_n)[*8]
    ##1 pins.read_strobe_n) else $error("read strobe pulse wrong");
  a_rd_pulse: assert property (rd_valid |->
    pins.read_strobe_n && !$past(pins.read_strobe_n)) else $error("rd_valid misplaced");
  a_busy_seen: assert property ($fell(ready_busy_n) |-> ##[1:3] busy)
    else $error("busy not reported");
  cover property ($rose(rd_valid));
  cover property ($rose(busy));
  cover property (pins.addr_latch && $rose(pins.write_strobe_n));
endmodule
bind nfh_host nfh_monitor u_nfh_monitor (.clk, .nrst, .chip_en, .write_prot_n, .rd_valid,
  .busy, .pins, .ready_busy_n);

// *** dv/nfh_flash_model.sv ***
`timescale 1ns/10ps
// Behavioural flash device; no clock, acts on strobe edges and toggles a released bus every 4 ns
module nfh_flash_model
  import nfh_pkg::*;
(
  input wire nfh_pins_type pins,
  output logic [7:0] dq,
  output logic rb_low
);
  logic [7:0] page [0:2111];
  logic [7:0] adr [0:4]; // Last address bytes seen
  logic [7:0] cmd_q; // Last command byte
  logic [11:0] col; // Column pointer
  int ac = 0; // Address cycle count
  logic rd_on = 0; // Byte valid on the bus
  // Row from cycles three to five: block above, page below, bit 6 the plane
  wire [16:0] row = {adr[4][0], adr[3], adr[2]};
  wire [10:0] blk = row[16:6];
  wire [5:0] pg = row[5:0];
  wire plane = row[6];
  initial begin
    dq = 8'h00;
    rb_low = 0;
  end
  // Released bus toggles so a stale byte never looks valid
  always #4 if (!rd_on) dq = ~dq;
  // Byte appears one access delay after the strobe falls
  always @(negedge pins.read_strobe_n) if (!pins.chip_sel_n) begin
    #20 dq = page[col];
    rd_on = 1;
  end
  // Column moves on every read pulse
  always @(posedge pins.read_strobe_n) if (rd_on) begin
    col = col + 12'h001;
    rd_on = 0;
  end
  // Capture on the write strobe rising edge
  always @(posedge pins.write_strobe_n) if (!pins.chip_sel_n && !rb_low) begin
    if (pins.cmd_latch) begin
      cmd_q = pins.io_out;
      ac = 0;
      if (cmd_q == 8'h30 || (pins.write_prot_n && (cmd_q == 8'h10 || cmd_q == 8'hD0))) begin
        rb_low = 1;
        #200 rb_low = 0;
      end
    end else if (pins.addr_latch) begin
      if (ac < 5) adr[ac] = pins.io_out;
      if (ac == 1) col = {adr[1][3:0], adr[0]};
      ac++;
    end else begin
      page[col] = pins.io_out;
      col = col + 12'h001;
    end
  end
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench;
  import nfh_pkg::*;
  logic clk = 0, nrst = 0, req_valid = 0, chip_en = 1, write_prot_n = 1;
  nfh_req_type req = '0;
  logic req_ready, rd_valid, busy, rb_low;
  logic [7:0] rd_data, dq;
  nfh_pins_type pins;
  // Shared eight-bit bus as both ends see it
  wire [7:0] io_in = (pins.io_oe == 8'hFF) ? pins.io_out : dq;
  wire ready_busy_n = !rb_low;
  int fails = 0, total_checks = 0;
  nfh_host u_nfh_host (.clk, .nrst, .req_valid, .req_ready, .req, .chip_en, .write_prot_n,
    .rd_data, .rd_valid, .busy, .pins, .io_in, .ready_busy_n);
  nfh_flash_model u_nfh_flash_model (.pins, .dq, .rb_low);
  initial forever #2 clk = ~clk;
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Bounded wait on ready (0), busy (1) or rd_valid (2)
  task wait_on(input int w, input logic lvl);
    int i;
    for (i = 0; i < 400 && (w == 0 ? req_ready : w == 1 ? busy : rd_valid) !== lvl; i++)
      @(negedge clk);
    if (i == 400) begin
      fails++;
      $display("mismatch wait_on %0d expected %b seen %b", w, lvl, !lvl);
      tally_and_finish();
    end
  endtask
  // One request, held until the taking edge
  task send(input nfh_op_type op, input logic [7:0] d, input logic [11:0] c = 12'h000,
    input logic [16:0] r = 17'h0_0000);
    wait_on(0, 1);
    @(posedge clk);
    req <= '{op, d, c, r};
    req_valid <= 1;
    @(posedge clk);
    req_valid <= 0;
    @(negedge clk);
  endtask
  task rd(input logic [7:0] e);
    send(NFH_OP_READ, 8'h00);
    wait_on(2, 1);
    `CHK("rd_data", e, rd_data)
  endtask
  task t_program_read;
    send(NFH_OP_CMD, 8'h80);
    send(NFH_OP_ADDR5, 8'h00, 12'h7FE, 17'h1_2345);
    send(NFH_OP_WRITE, 8'hA5);
    send(NFH_OP_WRITE, 8'h3C);
    send(NFH_OP_CMD, 8'h10);
    wait_on(1, 1);
    wait_on(1, 0);
    `CHK("adr1", 8'h07, u_nfh_flash_model.adr[1])
    `CHK("adr2", 8'h45, u_nfh_flash_model.adr[2])
    `CHK("adr4", 8'h01, u_nfh_flash_model.adr[4])
    `CHK("block", 11'h48D, u_nfh_flash_model.blk)
    `CHK("page", 6'h05, u_nfh_flash_model.pg)
    `CHK("plane", 1'b1, u_nfh_flash_model.plane)
    send(NFH_OP_CMD, 8'h00);
    send(NFH_OP_ADDR, 8'h00, 12'h7FE);
    send(NFH_OP_CMD, 8'h30);
    wait_on(1, 1);
    wait_on(1, 0);
    rd(8'hA5);
    rd(8'h3C);
  endtask
  // Erase confirm while protected must leave the device idle
  task t_protect;
    @(posedge clk) write_prot_n <= 0;
    send(NFH_OP_CMD, 8'h60);
    send(NFH_OP_CMD, 8'hD0);
    repeat (12) @(negedge clk);
    `CHK("busy", 1'b0, busy)
    `CHK("wp_pin", 1'b0, pins.write_prot_n)
    @(posedge clk) write_prot_n <= 1;
  endtask
  task t_chip_off;
    @(posedge clk) chip_en <= 0;
    @(negedge clk);
    `CHK("req_ready", 1'b0, req_ready)
    `CHK("chip_sel_n", 1'b1, pins.chip_sel_n)
    @(posedge clk) chip_en <= 1;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1;
    t_program_read();
    t_protect();
    t_chip_off();
    tally_and_finish();
  end
endmodule
